// ### storage_fault_pkg.sv
`default_nettype none
package storage_fault_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_RET    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MSTATE = 8'h08;
  localparam logic [7:0] OFS_CAUSE  = 8'h0c;
  localparam logic [7:0] OFS_LOC    = 8'h10;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  // architectural bit n sits at vector index 31-n (bit 0 is the msb)
  localparam int MS_EE = 15;
  localparam int MS_PR = 14;
  localparam int MS_FP = 13;
  localparam int MS_ME = 12;
  localparam int MS_FE = 11;
  localparam int MS_AL = 7;
  localparam int MS_IP = 6;
  localparam int MS_IR = 5;
  localparam int MS_DR = 4;
  localparam logic [31:0] MS_DEFINED     = 32'h0000f8f0;
  localparam logic [31:0] MS_ENTRY_CLEAR = 32'h0000e8b0;
  localparam logic [31:0] MS_RESET       = 32'h00000000;
  localparam logic [31:0] STATUS_KEEP    = 32'h0000ffff;
  localparam logic [31:0] CAUSE_DEFINED  = 32'hff000000;
  localparam logic [31:0] REG_RESET      = 32'h00000000;
  localparam int DC_IO       = 31;
  localparam int DC_NOTFOUND = 30;
  localparam int DC_LOCK     = 29;
  localparam int DC_FLTIO    = 28;
  localparam int DC_PROT     = 27;
  localparam int DC_LOOP     = 26;
  localparam int DC_STORE    = 25;
  localparam int DC_CROSS    = 24;
  localparam int IS_NOTFOUND = 30;
  localparam int IS_SPECIAL  = 29;
  localparam int IS_IOSEG    = 28;
  localparam int IS_PROT     = 27;
  localparam int IS_LOOP     = 26;
  localparam logic [31:0] VEC_DATA  = 32'h00000300;
  localparam logic [31:0] VEC_FETCH = 32'h00000400;
  localparam logic [7:0]  LOOP_LIMIT = 8'h7f;
  localparam logic [31:0] WORD_ALIGN = 32'hfffffffc;
  localparam logic [31:0] DWORD_ALIGN = 32'hfffffff8;

  typedef enum logic [1:0] {
    SZ_FIXED  = 2'h0,
    SZ_SINGLE = 2'h1,
    SZ_DOUBLE = 2'h3
  } access_size_t;

  typedef enum logic [1:0] {
    SRC_LDST  = 2'h0,
    SRC_STCTL = 2'h1,
    SRC_CACHE = 2'h3
  } op_src_t;

  typedef struct packed {
    logic         valid;
    op_src_t      src;
    access_size_t size;
    logic         store;
    logic         io_exc;
    logic         not_found;
    logic         lock_deny;
    logic         float_io;
    logic         prot;
    logic         loop;
    logic         cross_io;
    logic [7:0]   search_cnt;
    logic [31:0]  insn_addr;
    logic [31:0]  page_ea;
    logic [31:0]  io_ea;
  } data_fault_t;

  typedef struct packed {
    logic        valid;
    logic        not_found;
    logic        special_seg;
    logic        io_seg;
    logic        prot;
    logic        loop;
    logic [7:0]  search_cnt;
    logic [31:0] fetch_addr;
  } fetch_fault_t;

  typedef struct packed {
    logic        valid;
    logic        from_fetch;
    logic [31:0] pc;
  } redirect_t;
endpackage
`default_nettype wire

// ### storage_fault_entry.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - data fault causes trigger data fault entry
// - io subsystem failure raises io exception
// - loads, stores, storage and cache ops fault
// - return address gets failing instruction address
// - saved status: upper half zero, lower copied
// - data fault resumes at base plus 0x300
// - cause bit 0 marks io exception
// - cause bit 1 marks chain end, not found
// - cause bit 2 marks data-lock refusal
// - cause bit 3 marks floating io access
// - cause bit 4 marks page protection
// - cause bit 5 marks translation loop
// - cause bit 6 is store, not load
// - cause bit 7 crossing; 8-14 zero
// - fixed/single: fault address in first word
// - double: fault address in first doubleword
// - io exception: fault address is io address
// - fetch fault causes trigger fetch fault entry
// - only fetches raise fetch fault entry
// - return address gets fetched instruction address
// - fetch fault resumes at base plus 0x400
// - status bit 2 marks special segment fetch
module storage_fault_entry #(
  parameter logic [31:0] VEC_BASE_LO = 32'h00000000,
  parameter logic [31:0] VEC_BASE_HI = 32'hfff00000
) (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  input  wire storage_fault_pkg::data_fault_t  dfault,
  input  wire storage_fault_pkg::fetch_fault_t ffault,
  output storage_fault_pkg::redirect_t     redirect,
  output logic [31:0]                      machine_state
);
  logic        rst_s1_q;
  logic        rst_n_q;
  logic [31:0] saved_return_addr_q;
  logic [31:0] saved_status_q;
  logic [31:0] machine_state_q;
  logic [31:0] data_fault_cause_q;
  logic [31:0] data_fault_loc_q;
  logic        wr_pend_q;
  logic [7:0]  wr_ofs_q;
  logic [31:0] hrdata_q;
  storage_fault_pkg::redirect_t redirect_q;
  logic        d_take;
  logic        f_take;
  logic        bus_acc;
  logic [31:0] cause_d;
  logic [31:0] fstatus_d;
  logic [31:0] loc_d;
  logic [31:0] base;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  function automatic logic [31:0] reg_read(input logic [7:0] ofs,
                                           input logic [31:0] r0,
                                           input logic [31:0] r1,
                                           input logic [31:0] ms,
                                           input logic [31:0] dc,
                                           input logic [31:0] dl);
    case (ofs)
      storage_fault_pkg::OFS_RET:    reg_read = r0;
      storage_fault_pkg::OFS_STATUS: reg_read = r1;
      storage_fault_pkg::OFS_MSTATE: reg_read = ms;
      storage_fault_pkg::OFS_CAUSE:  reg_read = dc;
      storage_fault_pkg::OFS_LOC:    reg_read = dl;
      default:                       reg_read = 32'h00000000;
    endcase
  endfunction

  // a data fault belongs to an older instruction than any pending fetch
  // fault, so it wins; the core refetches and meets the fetch fault again
  assign d_take = dfault.valid;
  assign f_take = ffault.valid && !dfault.valid;

  always_comb begin
    cause_d = 32'h00000000;
    cause_d[storage_fault_pkg::DC_IO]       = dfault.io_exc;
    cause_d[storage_fault_pkg::DC_NOTFOUND] = dfault.not_found;
    cause_d[storage_fault_pkg::DC_LOCK]     = dfault.lock_deny;
    cause_d[storage_fault_pkg::DC_FLTIO]    = dfault.float_io;
    cause_d[storage_fault_pkg::DC_PROT]     = dfault.prot;
    cause_d[storage_fault_pkg::DC_LOOP]     = dfault.loop ||
      (dfault.search_cnt > storage_fault_pkg::LOOP_LIMIT);
    cause_d[storage_fault_pkg::DC_STORE]    = dfault.store;
    cause_d[storage_fault_pkg::DC_CROSS]    = dfault.cross_io;
  end

  always_comb begin
    fstatus_d = machine_state_q & storage_fault_pkg::STATUS_KEEP;
    fstatus_d[storage_fault_pkg::IS_NOTFOUND] = ffault.not_found;
    fstatus_d[storage_fault_pkg::IS_SPECIAL]  = ffault.special_seg;
    fstatus_d[storage_fault_pkg::IS_IOSEG]    = ffault.io_seg &&
      machine_state_q[storage_fault_pkg::MS_IR];
    fstatus_d[storage_fault_pkg::IS_PROT]     = ffault.prot;
    fstatus_d[storage_fault_pkg::IS_LOOP]     = ffault.loop ||
      (ffault.search_cnt > storage_fault_pkg::LOOP_LIMIT);
  end

  always_comb begin
    if (dfault.io_exc) begin
      loc_d = dfault.io_ea;
    end else if (dfault.size == storage_fault_pkg::SZ_DOUBLE) begin
      loc_d = dfault.page_ea & storage_fault_pkg::DWORD_ALIGN;
    end else begin
      loc_d = dfault.page_ea & storage_fault_pkg::WORD_ALIGN;
    end
  end

  assign base = machine_state_q[storage_fault_pkg::MS_IP] ? VEC_BASE_HI
                                                          : VEC_BASE_LO;

  // ahb-lite slave: zero wait states, always okay
  assign bus_acc = hsel && hready && htrans[1];

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= 8'h00;
      hrdata_q  <= 32'h00000000;
    end else begin
      if (hready) begin
        // reads decode the full address, so writes must as well
        wr_pend_q <= bus_acc && hwrite &&
                     (hsize == storage_fault_pkg::HSIZE_WORD) &&
                     (haddr[31:8] == 24'h000000);
        wr_ofs_q  <= haddr[7:0];
      end
      if (bus_acc && !hwrite && haddr[31:8] == 24'h000000) begin
        hrdata_q <= reg_read(haddr[7:0], saved_return_addr_q,
                             saved_status_q, machine_state_q,
                             data_fault_cause_q, data_fault_loc_q);
      end else if (bus_acc) begin
        hrdata_q <= 32'h00000000;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // a fault entry in the same cycle as a software write wins: the handler
  // must see the hardware values, not a stale store that raced it
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      saved_return_addr_q <= storage_fault_pkg::REG_RESET;
    end else if (d_take) begin
      saved_return_addr_q <= dfault.insn_addr;
    end else if (f_take) begin
      saved_return_addr_q <= ffault.fetch_addr;
    end else if (wr_pend_q && wr_ofs_q == storage_fault_pkg::OFS_RET) begin
      saved_return_addr_q <= hwdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      saved_status_q <= storage_fault_pkg::REG_RESET;
    end else if (d_take) begin
      saved_status_q <= machine_state_q & storage_fault_pkg::STATUS_KEEP;
    end else if (f_take) begin
      saved_status_q <= fstatus_d;
    end else if (wr_pend_q &&
                 wr_ofs_q == storage_fault_pkg::OFS_STATUS) begin
      saved_status_q <= hwdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      machine_state_q <= storage_fault_pkg::MS_RESET;
    end else if (d_take || f_take) begin
      machine_state_q <= machine_state_q &
                         ~storage_fault_pkg::MS_ENTRY_CLEAR;
    end else if (wr_pend_q &&
                 wr_ofs_q == storage_fault_pkg::OFS_MSTATE) begin
      machine_state_q <= hwdata & storage_fault_pkg::MS_DEFINED;
    end
  end

  assign machine_state = machine_state_q;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      data_fault_cause_q <= storage_fault_pkg::REG_RESET;
      data_fault_loc_q   <= storage_fault_pkg::REG_RESET;
    end else if (d_take) begin
      data_fault_cause_q <= cause_d;
      data_fault_loc_q   <= loc_d;
    end else if (wr_pend_q) begin
      if (wr_ofs_q == storage_fault_pkg::OFS_CAUSE) begin
        data_fault_cause_q <= hwdata & storage_fault_pkg::CAUSE_DEFINED;
      end
      if (wr_ofs_q == storage_fault_pkg::OFS_LOC) begin
        data_fault_loc_q <= hwdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      redirect_q <= '0;
    end else begin
      redirect_q.valid      <= d_take || f_take;
      redirect_q.from_fetch <= f_take;
      if (d_take) begin
        redirect_q.pc <= base | storage_fault_pkg::VEC_DATA;
      end else if (f_take) begin
        redirect_q.pc <= base | storage_fault_pkg::VEC_FETCH;
      end
    end
  end

  assign redirect = redirect_q;

  property p_ret_data;
    @(posedge clk) disable iff (!rst_n_q)
    dfault.valid |=> saved_return_addr_q == $past(dfault.insn_addr);
  endproperty
  a_ret_data: assert property (p_ret_data)
    else $error("return address not the failing instruction");

  property p_ret_fetch;
    @(posedge clk) disable iff (!rst_n_q)
    (ffault.valid && !dfault.valid) |=>
      saved_return_addr_q == $past(ffault.fetch_addr);
  endproperty
  a_ret_fetch: assert property (p_ret_fetch)
    else $error("return address not the fetched instruction");

  property p_status_copy;
    @(posedge clk) disable iff (!rst_n_q)
    dfault.valid |=> saved_status_q[31:16] == 16'h0000 &&
      saved_status_q[15:0] == $past(machine_state_q[15:0]);
  endproperty
  a_status_copy: assert property (p_status_copy)
    else $error("saved status wrong after data fault");

  property p_state_clear;
    @(posedge clk) disable iff (!rst_n_q)
    (dfault.valid || ffault.valid) |=>
      machine_state_q == ($past(machine_state_q) & 32'h00001040);
  endproperty
  a_state_clear: assert property (p_state_clear)
    else $error("machine state bits wrong after entry");

  property p_vec_data;
    @(posedge clk) disable iff (!rst_n_q)
    dfault.valid |=> redirect.valid && !redirect.from_fetch &&
      redirect.pc[11:0] == 12'h300;
  endproperty
  a_vec_data: assert property (p_vec_data)
    else $error("data fault did not resume at its vector");

  property p_vec_fetch;
    @(posedge clk) disable iff (!rst_n_q)
    (ffault.valid && !dfault.valid) |=> redirect.valid &&
      redirect.from_fetch && redirect.pc[11:0] == 12'h400;
  endproperty
  a_vec_fetch: assert property (p_vec_fetch)
    else $error("fetch fault did not resume at its vector");

  property p_cause_io;
    @(posedge clk) disable iff (!rst_n_q)
    dfault.valid |=> data_fault_cause_q[31] == $past(dfault.io_exc) &&
      data_fault_cause_q[25] == $past(dfault.store);
  endproperty
  a_cause_io: assert property (p_cause_io)
    else $error("io or store cause bit wrong");

  property p_cause_loop;
    @(posedge clk) disable iff (!rst_n_q)
    (dfault.valid && dfault.search_cnt >= 8'd128) |=>
      data_fault_cause_q[26];
  endproperty
  a_cause_loop: assert property (p_cause_loop)
    else $error("long search not reported as loop");

  property p_cause_zero;
    @(posedge clk) disable iff (!rst_n_q)
    dfault.valid |=> data_fault_cause_q[23:17] == 7'h00;
  endproperty
  a_cause_zero: assert property (p_cause_zero)
    else $error("reserved cause bits not zero");

  property p_special;
    @(posedge clk) disable iff (!rst_n_q)
    (ffault.valid && !dfault.valid) |=>
      saved_status_q[29] == $past(ffault.special_seg);
  endproperty
  a_special: assert property (p_special)
    else $error("special segment bit wrong");

  property p_one_entry;
    @(posedge clk) disable iff (!rst_n_q)
    redirect.valid |-> $past(dfault.valid) ^
      ($past(ffault.valid) && redirect.from_fetch);
  endproperty
  a_one_entry: assert property (p_one_entry)
    else $error("entry kind does not match its cause");

  property p_loc_io;
    @(posedge clk) disable iff (!rst_n_q)
    (dfault.valid && dfault.io_exc) |=>
      data_fault_loc_q == $past(dfault.io_ea);
  endproperty
  a_loc_io: assert property (p_loc_io)
    else $error("fault address not the io address");

  property p_cause_notfound;
    @(posedge clk) disable iff (!rst_n_q)
    dfault.valid |=> data_fault_cause_q[storage_fault_pkg::DC_NOTFOUND] ==
      $past(dfault.not_found);
  endproperty
  a_cause_notfound: assert property (p_cause_notfound)
    else $error("chain end cause bit wrong");

  property p_cause_lock;
    @(posedge clk) disable iff (!rst_n_q)
    dfault.valid |=> data_fault_cause_q[storage_fault_pkg::DC_LOCK] ==
      $past(dfault.lock_deny);
  endproperty
  a_cause_lock: assert property (p_cause_lock)
    else $error("data lock cause bit wrong");

  property p_cause_fltio;
    @(posedge clk) disable iff (!rst_n_q)
    dfault.valid |=> data_fault_cause_q[storage_fault_pkg::DC_FLTIO] ==
      $past(dfault.float_io);
  endproperty
  a_cause_fltio: assert property (p_cause_fltio)
    else $error("floating io cause bit wrong");

  property p_cause_prot;
    @(posedge clk) disable iff (!rst_n_q)
    dfault.valid |=> data_fault_cause_q[storage_fault_pkg::DC_PROT] ==
      $past(dfault.prot);
  endproperty
  a_cause_prot: assert property (p_cause_prot)
    else $error("protection cause bit wrong");

  property p_loc_word;
    @(posedge clk) disable iff (!rst_n_q)
    (dfault.valid && !dfault.io_exc &&
     dfault.size != storage_fault_pkg::SZ_DOUBLE) |=>
      data_fault_loc_q[31:2] == $past(dfault.page_ea[31:2]);
  endproperty
  a_loc_word: assert property (p_loc_word)
    else $error("fault address outside the first word");

  property p_loc_dword;
    @(posedge clk) disable iff (!rst_n_q)
    (dfault.valid && !dfault.io_exc &&
     dfault.size == storage_fault_pkg::SZ_DOUBLE) |=>
      data_fault_loc_q[31:3] == $past(dfault.page_ea[31:3]);
  endproperty
  a_loc_dword: assert property (p_loc_dword)
    else $error("fault address outside the first doubleword");
endmodule // storage_fault_entry
`default_nettype wire

// ### fault_src.sv
`timescale 1ns/1ns
`default_nettype none
module fault_src (
  input  wire logic                           clk,
  output var storage_fault_pkg::data_fault_t  dfault,
  output var storage_fault_pkg::fetch_fault_t ffault
);
  initial begin
    dfault = '0;
    ffault = '0;
  end

  // one-cycle pulses; once released the fields show the inverse of the
  // last value, so a stale field can never pass for a fresh one
  task automatic send(input storage_fault_pkg::data_fault_t  d,
                      input storage_fault_pkg::fetch_fault_t f);
    storage_fault_pkg::data_fault_t  dr;
    storage_fault_pkg::fetch_fault_t fr;
    dr = ~d;
    fr = ~f;
    dr.valid = 1'b0;
    fr.valid = 1'b0;
    dfault <= d;
    ffault <= f;
    @(posedge clk);
    dfault <= dr;
    ffault <= fr;
  endtask
endmodule // fault_src
`default_nettype wire

// ### storage_fault_interrupt_entry_tb.sv
`timescale 1ns/1ns
`default_nettype none
module storage_fault_interrupt_entry_tb;
  localparam logic [31:0] BASE_HI = 32'hfff00000;
  logic                            clk    = 1'b0;
  logic                            arst_n = 1'b0;
  logic                            hsel   = 1'b0;
  logic [31:0]                     haddr  = 32'h0;
  logic [1:0]                      htrans = 2'h0;
  logic                            hwrite = 1'b0;
  logic [2:0]                      hsize  = 3'h0;
  logic [31:0]                     hwdata = 32'h0;
  wire logic                       hreadyout;
  wire logic                       hresp;
  wire logic [31:0]                hrdata;
  wire logic [31:0]                machine_state;
  wire storage_fault_pkg::data_fault_t  dfault;
  wire storage_fault_pkg::fetch_fault_t ffault;
  wire storage_fault_pkg::redirect_t    redirect;
  int                              fail_count  = 0;
  int                              comparisons = 0;

  always #20 clk = ~clk;

  storage_fault_entry #(.VEC_BASE_LO(32'h0), .VEC_BASE_HI(BASE_HI)) u_dut (
    .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .dfault(dfault), .ffault(ffault),
    .redirect(redirect), .machine_state(machine_state));

  fault_src u_src (.clk(clk), .dfault(dfault), .ffault(ffault));

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // single transfer; waits on hready at each phase, bench timeout bounds it
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, input logic [2:0] sz,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= storage_fault_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] rd;
    ahb(1'b1, a, v, storage_fault_pkg::HSIZE_WORD, rd);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, $urandom, storage_fault_pkg::HSIZE_WORD, rd);
    chk(what, exp, rd);
  endtask

  function automatic storage_fault_pkg::data_fault_t rand_d(input int i);
    storage_fault_pkg::data_fault_t d;
    d = '0;
    d.valid = 1'b1;
    d.src = (i % 3 == 0) ? storage_fault_pkg::SRC_LDST :
            (i % 3 == 1) ? storage_fault_pkg::SRC_STCTL :
                           storage_fault_pkg::SRC_CACHE;
    d.size = (i % 3 == 1) ? storage_fault_pkg::SZ_FIXED :
             (i % 3 == 2) ? storage_fault_pkg::SZ_SINGLE :
                            storage_fault_pkg::SZ_DOUBLE;
    {d.store, d.io_exc, d.not_found, d.lock_deny, d.float_io, d.prot,
     d.loop, d.cross_io} = 8'($urandom);
    if (!(d.io_exc | d.not_found | d.lock_deny | d.float_io | d.prot |
          d.loop | d.cross_io)) d.prot = 1'b1;
    d.search_cnt = 8'($urandom);
    d.insn_addr = $urandom;
    d.page_ea = $urandom;
    d.io_ea = $urandom;
    return d;
  endfunction

  function automatic storage_fault_pkg::fetch_fault_t rand_f();
    storage_fault_pkg::fetch_fault_t f;
    f.valid = 1'b1;
    {f.not_found, f.special_seg, f.io_seg, f.prot, f.loop} = 5'($urandom);
    if ({f.not_found, f.special_seg, f.io_seg, f.prot, f.loop} == 5'h0)
      f.prot = 1'b1;
    f.search_cnt = 8'($urandom);
    f.fetch_addr = $urandom;
    return f;
  endfunction

  task automatic fault(input storage_fault_pkg::data_fault_t  d,
                       input storage_fault_pkg::fetch_fault_t f);
    logic [31:0] ms0;
    logic [31:0] st;
    logic [31:0] cs;
    logic [31:0] pc;
    logic [31:0] loc;
    ms0 = $urandom & storage_fault_pkg::MS_DEFINED;
    wr(storage_fault_pkg::OFS_MSTATE, ms0);
    u_src.send(d, f);
    #1;
    pc = (ms0[storage_fault_pkg::MS_IP] ? BASE_HI : 32'h0) |
         (d.valid ? storage_fault_pkg::VEC_DATA : storage_fault_pkg::VEC_FETCH);
    chk("redirect_valid", 32'h1, 32'(redirect.valid));
    chk("redirect_pc", pc, redirect.pc);
    chk("from_fetch", 32'(!d.valid), 32'(redirect.from_fetch));
    chk("ms_port", ms0 & ~storage_fault_pkg::MS_ENTRY_CLEAR,
        machine_state);
    st = ms0 & storage_fault_pkg::STATUS_KEEP;
    if (!d.valid) begin
      st[storage_fault_pkg::IS_NOTFOUND] = f.not_found;
      st[storage_fault_pkg::IS_SPECIAL] = f.special_seg;
      st[storage_fault_pkg::IS_IOSEG] =
        f.io_seg & ms0[storage_fault_pkg::MS_IR];
      st[storage_fault_pkg::IS_PROT] = f.prot;
      st[storage_fault_pkg::IS_LOOP] = f.loop | (f.search_cnt > 8'h7f);
    end
    rdchk("saved_return_addr", storage_fault_pkg::OFS_RET,
          d.valid ? d.insn_addr : f.fetch_addr);
    chk("redirect_pulse", 32'h0, 32'(redirect.valid));
    rdchk("saved_status", storage_fault_pkg::OFS_STATUS, st);
    rdchk("machine_state", storage_fault_pkg::OFS_MSTATE,
          ms0 & ~storage_fault_pkg::MS_ENTRY_CLEAR);
    if (d.valid) begin
      cs = {d.io_exc, d.not_found, d.lock_deny, d.float_io, d.prot,
            d.loop | (d.search_cnt > 8'h7f), d.store, d.cross_io, 24'h0};
      rdchk("data_fault_cause", storage_fault_pkg::OFS_CAUSE,
            cs);
      loc = d.io_exc ? d.io_ea : d.page_ea &
            (d.size == storage_fault_pkg::SZ_DOUBLE ?
             storage_fault_pkg::DWORD_ALIGN : storage_fault_pkg::WORD_ALIGN);
      rdchk("data_fault_loc", storage_fault_pkg::OFS_LOC,
            loc);
    end
  endtask

  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    storage_fault_pkg::data_fault_t d;
    logic [31:0]                    rd;
    void'($urandom(32'h9310eac3));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 6; a++) rdchk("reset_value", 8'(a * 4), 32'h0);
    wr(storage_fault_pkg::OFS_MSTATE, 32'hffffffff);
    rdchk("ms_defined", storage_fault_pkg::OFS_MSTATE,
          storage_fault_pkg::MS_DEFINED);
    wr(storage_fault_pkg::OFS_CAUSE, 32'hffffffff);
    rdchk("cause_defined", storage_fault_pkg::OFS_CAUSE,
          storage_fault_pkg::CAUSE_DEFINED);
    wr(8'h14, 32'hffffffff);
    rdchk("unmapped", 8'h14, 32'h0);
    ahb(1'b1, storage_fault_pkg::OFS_RET, 32'h5a5a5a5a, 3'h0, rd);
    rdchk("narrow_write", storage_fault_pkg::OFS_RET, 32'h0);
    rd = $urandom;
    wr(storage_fault_pkg::OFS_LOC, rd);
    rdchk("loc_rw", storage_fault_pkg::OFS_LOC, rd);
    for (int i = 0; i < 15; i++) fault(rand_d(i), '0);
    for (int i = 0; i < 8; i++) fault('0, rand_f());
    for (int c = 127; c < 129; c++) begin
      d = rand_d(c);
      d.loop = 1'b0;
      d.search_cnt = 8'(c);
      fault(d, '0);
    end
    d = '0;
    d.valid = 1'b1;
    d.io_exc = 1'b1;
    d.io_ea = $urandom;
    fault(d, '0);
    for (int i = 0; i < 3; i++) fault(rand_d(i), rand_f());
    report_and_stop();
  end
endmodule // storage_fault_interrupt_entry_tb
`default_nettype wire
